/* src/pxs_sense_ctrl.sv */
// Proximity sensor command registers, serial target and measurement scheduler
//
// Contract
// RULE_01: Host sets bias enable, then init ready.
// RULE_02: Config low bit 0 resets one, kept one.
// RULE_03: Sample period selects 10/20/40/80 ms.
// RULE_04: Persistence needs 1 to 4 consecutive exceedings.
// RULE_05: Mode field: off, logic, first-high, normal.
// RULE_06: Smart persistence enable bit.
// RULE_07: Stop bit resets one; zero starts measuring.
// RULE_08: Host selects force mode before starting.
// RULE_09: Integration time and time base settings.
// RULE_10: Pulse count and high gain settings.
// RULE_11: Force mode select versus automatic periodic.
// RULE_12: Force trigger measures, then self-clears.
// RULE_13: Host writes reserved bit 3 as one.
// RULE_14: Sunlight cancel needs all three bits set.
// RULE_15: Emitter current code drives sink current.
// RULE_16: Thresholds are 12 bits, low byte first.
// RULE_17: Crosstalk cancel level is 12 bits.
// RULE_18: Calibration period, sample count, done interrupt.
// RULE_19: Calibration needs force mode; trigger runs once.
// RULE_20: Low power period 40 to 320 ms.
// RULE_21: Result returned as 12 bits, low first.
// RULE_22: Flags: near, far, calibration done, sunlight.
// RULE_23: Calibration busy, sunlight and upper result.
// RULE_24: Reading flags clears them, releases pin.
// RULE_25: Only address 0x60, word transfers only.
// RULE_26: First-high mode ignores far until near.
// RULE_27: Low data byte first, then high.
// RULE_28: Interrupt pin low while enabled flag set.
`timescale 1ns/10ps
module pxs_sense_ctrl #(
   parameter int TICK_CYCLES = pxs_pkg::TICK_CYC, // Cycles per 1 ms tick
   parameter logic [7:0] IDENT_LO = 8'h5A, // Identity value, arbitrary
   parameter logic [7:0] IDENT_HI = 8'h00 // Identity value, arbitrary
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic int_o,
   output logic int_oe,
   output logic fe_start,
   input wire logic [11:0] fe_result,
   input wire logic fe_valid,
   input wire logic fe_sun,
   output logic bias_on,
   output logic [7:0] integ_ctrl,
   output logic [3:0] emitter_current,
   output logic sun_cancel_en
);
   import pxs_pkg::*;

   // Pin synchronisers and previous sampled levels
   logic scl_m_r, scl_s_r, scl_d_r;
   logic sda_m_r, sda_s_r, sda_d_r;
   // Serial target state
   pxs_st_t st_r;
   logic [3:0] cnt_r; // Rising edges seen in the current byte
   logic [7:0] shift_r; // Received byte
   logic [7:0] tx_r; // Remaining bits of the byte being sent
   logic [7:0] cmd_r; // Command code of this transfer
   logic [7:0] wlo_r; // Low data byte held until the high byte lands
   logic hi_r; // Next data byte is the high one
   logic rw_r, ack_ok_r, sda_oe_r;
   // Command registers
   logic [7:0] c1lo_r, c1hi_r, c2lo_r, c2hi_r, c3_r, c4_r, acl_r, lp_r;
   logic [11:0] thl_r, thh_r, canc_r, res_r, acres_r;
   logic [7:0] flags_r;
   // Scheduler and evaluation state
   logic [15:0] tick_r;
   logic [8:0] ms_r;
   logic pend_r, fdone_r, quick_r, armed_r, near_st_r, sun_d_r;
   logic cal_busy_r, cal_sun_r;
   logic [2:0] cal_n_r, hcnt_r, lcnt_r;
   logic fe_start_r, int_oe_r, sc_en_r;

   // Decoded events
   logic scl_rise, scl_fall, bus_start, bus_stop, wr_go, tx_load, flag_rd;
   logic ms_tick, tick_fire, fire, run, forcing, trig_done;
   logic cal_go, cal_done, above, below, near_evt, far_evt, sun_evt;
   logic [1:0] imode;
   logic [2:0] need, hnext, lnext;
   logic [8:0] lim;
   logic [7:0] int_en;
   logic [7:0] tx_byte; // Next byte to send, low half first

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Interval in ms: a base doubled per select step
   function automatic logic [8:0] per_ms(input int base, input logic [1:0] sel);
      return 9'(base) << sel;
   endfunction

   // Byte returned for a read, low half first
   function automatic logic [7:0] rd_byte(input logic [7:0] c, input logic h);
      logic [15:0] w;
      w = 16'h0000;
      case (c)
         CMD_CONF1: w = {c1hi_r, c1lo_r};
         CMD_CONF2: w = {c2hi_r, c2lo_r};
         CMD_CONF3: w = {c4_r, c3_r};
         CMD_THL: w = {4'h0, thl_r};
         CMD_THH: w = {4'h0, thh_r};
         CMD_CANC: w = {4'h0, canc_r};
         CMD_ACAL: w = {lp_r, acl_r};
         CMD_RES: w = {4'h0, res_r}; // see RULE_21
         CMD_FLAG: w = {flags_r, 8'h00};
         CMD_IDENT: w = {IDENT_HI, IDENT_LO};
         CMD_ACRES: w = {cal_busy_r, cal_sun_r, 2'b00, acres_r}; // see RULE_23
         default: w = 16'h0000;
      endcase
      return h ? w[15:8] : w[7:0]; // see RULE_27
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial link front

   // Two flops per pin before anything looks at it, third for edges
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_m_r <= scl_i;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_i;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   assign scl_rise = scl_s_r & ~scl_d_r;
   assign scl_fall = ~scl_s_r & scl_d_r;
   assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
   // Word write commits when the high byte has been taken
   assign wr_go = scl_fall & (cnt_r == 4'h8) & (st_r == ST_WDAT) & hi_r;
   // Next read byte is fetched at the end of an acknowledge slot
   assign tx_load = scl_fall & (cnt_r == 4'h9) &
                    (((st_r == ST_ADDR) & rw_r) | ((st_r == ST_RDAT) & ack_ok_r));
   assign flag_rd = tx_load & (cmd_r == CMD_FLAG) & hi_r; // see RULE_24
   // Fetched as a net so its top bit and the rest can be picked apart
   assign tx_byte = rd_byte(cmd_r, hi_r);

   // Target state machine; data changes only after a falling clock
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         cmd_r <= 8'h00;
         wlo_r <= 8'h00;
         hi_r <= 1'b0;
         rw_r <= 1'b0;
         ack_ok_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (bus_start) begin
         // Start or repeated start restarts the address phase
         st_r <= ST_ADDR;
         cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
         st_r <= ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (st_r != ST_IDLE && st_r != ST_WAIT) begin
         if (scl_rise) begin
            if (cnt_r < 4'h8) begin
               shift_r <= {shift_r[6:0], sda_s_r};
               cnt_r <= cnt_r + 4'h1;
            end else begin
               // Acknowledge slot: low means the host wants more
               ack_ok_r <= ~sda_s_r;
               cnt_r <= 4'h9;
            end
         end
         if (scl_fall) begin
            if (cnt_r == 4'h8) begin
               case (st_r)
                  ST_ADDR: begin
                     // Only the fixed address is answered
                     sda_oe_r <= (shift_r[7:1] == DEV_ADDR); // see RULE_25
                     rw_r <= shift_r[0];
                     if (shift_r[7:1] != DEV_ADDR) begin
                        st_r <= ST_WAIT;
                     end
                  end
                  ST_CMD: begin
                     sda_oe_r <= 1'b1;
                     cmd_r <= shift_r;
                     hi_r <= 1'b0;
                  end
                  ST_WDAT: begin
                     // Low byte first, high byte completes the word
                     sda_oe_r <= 1'b1;
                     wlo_r <= shift_r; // see RULE_27
                     hi_r <= ~hi_r;
                  end
                  default: sda_oe_r <= 1'b0;
               endcase
            end else if (cnt_r == 4'h9) begin
               cnt_r <= 4'h0;
               case (st_r)
                  ST_ADDR: st_r <= rw_r ? ST_RDAT : ST_CMD;
                  ST_CMD: st_r <= ST_WDAT;
                  ST_RDAT: begin
                     // A refused byte ends the read
                     if (!ack_ok_r) begin
                        st_r <= ST_WAIT;
                     end
                  end
                  default: st_r <= st_r;
               endcase
               if (tx_load) begin
                  tx_r <= {tx_byte[6:0], 1'b0};
                  sda_oe_r <= ~tx_byte[7];
                  hi_r <= ~hi_r;
               end else begin
                  sda_oe_r <= 1'b0;
               end
            end else if (cnt_r != 4'h0 && st_r == ST_RDAT) begin
               // Open drain: pull low for a zero bit
               sda_oe_r <= ~tx_r[7];
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command registers

   // Host writes; device-side clears of trigger bits lose to a new write
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         c1lo_r <= RST_CONF1_LO; // see RULE_02
         c1hi_r <= RST_ZERO;
         c2lo_r <= RST_CONF2_LO; // see RULE_07
         c2hi_r <= RST_ZERO;
         c3_r <= RST_ZERO;
         c4_r <= RST_ZERO;
         thl_r <= 12'h000;
         thh_r <= 12'h000;
         canc_r <= 12'h000;
         acl_r <= RST_ZERO;
         lp_r <= RST_ZERO;
      end else begin
         if (trig_done) begin
            c3_r[B_TRIG] <= 1'b0; // see RULE_12
         end
         if (cal_done) begin
            acl_r[B_ACTRIG] <= 1'b0; // see RULE_19
         end
         if (wr_go) begin
            case (cmd_r)
               CMD_CONF1: begin
                  c1lo_r <= wlo_r;
                  c1hi_r <= shift_r;
               end
               CMD_CONF2: begin
                  c2lo_r <= wlo_r;
                  c2hi_r <= shift_r; // see RULE_09
               end
               CMD_CONF3: begin
                  c3_r <= wlo_r; // see RULE_11
                  c4_r <= shift_r; // see RULE_15
               end
               CMD_THL: thl_r <= {shift_r[3:0], wlo_r}; // see RULE_16
               CMD_THH: thh_r <= {shift_r[3:0], wlo_r}; // see RULE_16
               CMD_CANC: canc_r <= {shift_r[3:0], wlo_r}; // see RULE_17
               CMD_ACAL: begin
                  acl_r <= wlo_r; // see RULE_18
                  lp_r <= shift_r;
               end
               default: lp_r <= lp_r; // Read-only codes ignore writes
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Measurement scheduling

   assign run = ~c2lo_r[B_STOP]; // see RULE_07
   assign imode = c2lo_r[F_IMODE +: 2]; // see RULE_05
   assign forcing = c3_r[B_AF] & c3_r[B_TRIG] & ~cal_busy_r;
   assign ms_tick = (tick_r == 16'(TICK_CYCLES - 1));
   // Interval choice: calibration, low power, or normal period
   assign lim = cal_busy_r ? per_ms(CAL_BASE_MS, acl_r[F_ACPER +: 2]) : // see RULE_18
                lp_r[B_LPEN] ? per_ms(LP_BASE_MS, lp_r[F_LPPER +: 2]) : // see RULE_20
                per_ms(MEAS_BASE_MS, c2lo_r[F_PERIOD +: 2]); // see RULE_03
   // Smart persistence re-measures on the next tick
   assign tick_fire = ms_tick & ((ms_r >= lim - 9'd1) | (quick_r & ~cal_busy_r));
   assign fire = ~pend_r & ((tick_fire & (cal_busy_r | (run & ~c3_r[B_AF]))) |
                            (run & forcing)); // see RULE_11
   assign trig_done = fe_valid & forcing & (fdone_r | ~c3_r[B_FNUM]); // see RULE_12
   assign cal_go = ~cal_busy_r & acl_r[B_ACEN] & acl_r[B_ACTRIG] & c3_r[B_AF]; // see RULE_19
   assign cal_done = cal_busy_r & fe_valid &
                     (cal_n_r == 3'((4'h1 << acl_r[F_ACNUM +: 2]) - 4'h1));

   // Millisecond tick and interval counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_r <= 16'h0000;
         ms_r <= 9'h000;
      end else begin
         tick_r <= ms_tick ? 16'h0000 : tick_r + 16'h0001;
         if (tick_fire || cal_go) begin
            ms_r <= 9'h000;
         end else if (ms_tick && ms_r < lim) begin
            ms_r <= ms_r + 9'h001;
         end
      end
   end

   // Front end requests and force-mode cycle count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fe_start_r <= 1'b0;
         pend_r <= 1'b0;
         fdone_r <= 1'b0;
      end else begin
         fe_start_r <= fire;
         pend_r <= fire | (pend_r & ~fe_valid);
         // One or two detect cycles per trigger
         fdone_r <= trig_done ? 1'b0 : (fdone_r | (fe_valid & forcing));
      end
   end

   // Calibration run: counts samples, keeps the last as its result
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cal_busy_r <= 1'b0;
         cal_sun_r <= 1'b0;
         cal_n_r <= 3'h0;
         acres_r <= 12'h000;
      end else if (cal_go) begin
         cal_busy_r <= 1'b1;
         cal_sun_r <= 1'b0;
         cal_n_r <= 3'h0;
      end else if (cal_busy_r) begin
         cal_sun_r <= cal_sun_r | fe_sun; // see RULE_23
         if (cal_done) begin
            cal_busy_r <= 1'b0;
            acres_r <= fe_result;
         end else if (fe_valid) begin
            cal_n_r <= cal_n_r + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Threshold evaluation and flags

   assign above = fe_result > thh_r;
   assign below = fe_result < thl_r;
   assign need = {1'b0, c2lo_r[F_PERS +: 2]} + 3'h1; // see RULE_04
   assign hnext = hcnt_r + 3'h1;
   assign lnext = lcnt_r + 3'h1;
   assign near_evt = fe_valid & ~cal_busy_r & above & (hnext == need);
   assign far_evt = fe_valid & ~cal_busy_r & below & (lnext == need);
   assign sun_evt = fe_sun & ~sun_d_r;
   assign int_en = {2'b00, acl_r[B_ACINT], c3_r[B_SPINT], 2'b00, {2{imode != IM_OFF}}};

   // Consecutive exceed counters, saturating at the persistence need
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hcnt_r <= 3'h0;
         lcnt_r <= 3'h0;
         quick_r <= 1'b0;
         res_r <= 12'h000;
      end else if (fe_valid && !cal_busy_r) begin
         res_r <= fe_result; // see RULE_21
         hcnt_r <= !above ? 3'h0 : (hcnt_r == need) ? need : hnext;
         lcnt_r <= !below ? 3'h0 : (lcnt_r == need) ? need : lnext;
         quick_r <= c2lo_r[B_SMART] & ((above & (hnext < need)) |
                                       (below & (lnext < need))); // see RULE_06
      end
   end

   // Sticky flags: a read clears, an event in the same cycle still lands
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flags_r <= 8'h00;
         armed_r <= 1'b0;
         near_st_r <= 1'b0;
         sun_d_r <= 1'b0;
      end else begin
         sun_d_r <= fe_sun;
         if (flag_rd) begin
            flags_r <= 8'h00; // see RULE_24
            armed_r <= 1'b0;
         end
         if (imode != IM_OFF && near_evt) begin
            flags_r[F_NEAR] <= 1'b1; // see RULE_22
            armed_r <= 1'b1;
            near_st_r <= 1'b1;
         end
         // First-high mode holds off far events until armed
         if (imode != IM_OFF && far_evt && (imode != IM_FIRST || armed_r)) begin
            flags_r[F_FAR] <= 1'b1; // see RULE_26
            near_st_r <= 1'b0;
         end
         if (cal_done) begin
            flags_r[F_CAL] <= 1'b1; // see RULE_22
         end
         if (sun_evt) begin
            flags_r[F_SUN] <= 1'b1; // see RULE_22
         end
      end
   end

   // Pin drive: logic mode follows the near state, others the flags
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         int_oe_r <= 1'b0;
         sc_en_r <= 1'b0;
      end else begin
         int_oe_r <= (imode == IM_LOGIC) ? near_st_r : |(flags_r & int_en); // see RULE_28
         sc_en_r <= &c4_r[F_SC +: 3]; // see RULE_14
      end
   end

   // Open-drain pins only ever pull low
   assign sda_o = 1'b0;
   assign int_o = 1'b0;
   assign sda_oe = sda_oe_r;
   assign int_oe = int_oe_r;
   assign fe_start = fe_start_r;
   assign bias_on = c1lo_r[B_BIAS];
   assign integ_ctrl = c2hi_r; // see RULE_10
   assign emitter_current = c4_r[3:0];
   assign sun_cancel_en = sc_en_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   chk_stop_blocks: assert property ( // see RULE_07
      fe_start_r && !cal_busy_r |-> $past(run))
      else $error("measurement started while stopped");
   chk_trig_clear: assert property ( // see RULE_12
      trig_done && !wr_go |=> !c3_r[B_TRIG])
      else $error("force trigger not cleared");
   chk_flag_clear: assert property ( // see RULE_24
      flag_rd && !near_evt && !far_evt && !cal_done && !sun_evt |=> flags_r == 8'h00)
      else $error("flag read did not clear");
   chk_addr_nack: assert property ( // see RULE_25
      scl_fall && cnt_r == 4'h8 && st_r == ST_ADDR && shift_r[7:1] != DEV_ADDR
      |=> !sda_oe_r && st_r == ST_WAIT)
      else $error("foreign address acknowledged");
   chk_first_high: assert property ( // see RULE_26
      imode == IM_FIRST && !armed_r && !flag_rd |=> flags_r[F_FAR] == $past(flags_r[F_FAR]))
      else $error("far flag before near event");
   chk_int_pin: assert property ( // see RULE_28
      imode == 2'b11 && (flags_r[F_NEAR] || flags_r[F_FAR]) ##1 imode == 2'b11 |-> int_oe_r)
      else $error("interrupt pin not pulled");
   chk_period_lim: assert property ( // see RULE_03
      fe_start_r && $past(run && !c3_r[B_AF] && !lp_r[B_LPEN] && !quick_r && !cal_busy_r)
      |-> $past(ms_r) + 9'd1 >= (9'(MEAS_BASE_MS) << $past(c2lo_r[F_PERIOD +: 2])))
      else $error("interval ended early");
   chk_cal_flag: assert property ( // see RULE_22
      $fell(cal_busy_r) |-> flags_r[F_CAL])
      else $error("calibration end without flag");
endmodule

/* shared/pxs_pkg.sv */
// Shared constants and types of the proximity sensing register block
package pxs_pkg;
   // Clock rate and the 1 ms scheduling tick derived from it
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // Shortest period of each interval family, in ms
   localparam int MEAS_BASE_MS = 10;
   localparam int LP_BASE_MS = 40;
   localparam int CAL_BASE_MS = 3;
   // Fixed bus target address
   localparam logic [6:0] DEV_ADDR = 7'h60;
   // Command codes
   localparam logic [7:0] CMD_CONF1 = 8'h00;
   localparam logic [7:0] CMD_CONF2 = 8'h03;
   localparam logic [7:0] CMD_CONF3 = 8'h04;
   localparam logic [7:0] CMD_THL = 8'h05;
   localparam logic [7:0] CMD_THH = 8'h06;
   localparam logic [7:0] CMD_CANC = 8'h07;
   localparam logic [7:0] CMD_ACAL = 8'h08;
   localparam logic [7:0] CMD_RES = 8'hF8;
   localparam logic [7:0] CMD_FLAG = 8'hF9;
   localparam logic [7:0] CMD_IDENT = 8'hFA;
   localparam logic [7:0] CMD_ACRES = 8'hFB;
   // Reset values
   localparam logic [7:0] RST_CONF1_LO = 8'h01;
   localparam logic [7:0] RST_CONF2_LO = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Field positions
   localparam int B_BIAS = 1;
   localparam int B_STOP = 0;
   localparam int B_SMART = 1;
   localparam int F_IMODE = 2;
   localparam int F_PERS = 4;
   localparam int F_PERIOD = 6;
   localparam int B_AF = 6;
   localparam int B_TRIG = 5;
   localparam int B_FNUM = 4;
   localparam int B_SPINT = 2;
   localparam int F_SC = 5;
   localparam int B_ACINT = 0;
   localparam int B_ACTRIG = 2;
   localparam int B_ACEN = 3;
   localparam int F_ACNUM = 4;
   localparam int F_ACPER = 6;
   localparam int B_LPEN = 0;
   localparam int F_LPPER = 1;
   localparam int F_FAR = 0;
   localparam int F_NEAR = 1;
   localparam int F_SUN = 4;
   localparam int F_CAL = 5;
   // Interrupt modes
   localparam logic [1:0] IM_OFF = 2'b00;
   localparam logic [1:0] IM_LOGIC = 2'b01;
   localparam logic [1:0] IM_FIRST = 2'b10;
   // Serial link states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_WDAT = 3'b011,
      ST_RDAT = 3'b100,
      ST_WAIT = 3'b101
   } pxs_st_t;
endpackage

/* bench/pxs_host_model.sv */
// Host bus master model for the serial register link
`timescale 1ns/10ps
module pxs_host_model (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // Both wires rest released; the clock moves only inside a frame
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // One 400 ns bit slot; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_pull = !b;
      #100 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
      #100;
   endtask
   // Eight bits, most significant first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q,
         output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ak, r);
      ok = !r;
   endtask
   // Start and repeated start share one shape
   task automatic start_cond;
      sda_pull = 1'b0;
      #100 scl = 1'b1;
      #100 sda_pull = 1'b1;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic stop_cond;
      sda_pull = 1'b1;
      #100 scl = 1'b1;
      #100 sda_pull = 1'b0;
      #200;
   endtask
   // Word write; the address is free so a wrong target can be tried
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
         output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start_cond();
      byte_io({a, 1'b0}, 1'b1, q, k0);
      byte_io(c, 1'b1, q, k1);
      byte_io(d[7:0], 1'b1, q, k2);
      byte_io(d[15:8], 1'b1, q, k3);
      stop_cond();
      ok = k0 & k1 & k2 & k3;
   endtask
   // Word read: low byte acknowledged, high byte refused
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      logic [7:0] q;
      logic k;
      start_cond();
      byte_io({pxs_pkg::DEV_ADDR, 1'b0}, 1'b1, q, k);
      byte_io(c, 1'b1, q, k);
      start_cond();
      byte_io({pxs_pkg::DEV_ADDR, 1'b1}, 1'b1, q, k);
      byte_io(8'hFF, 1'b0, d[7:0], k);
      byte_io(8'hFF, 1'b1, d[15:8], k);
      stop_cond();
   endtask
endmodule

/* bench/pxs_sense_ctrl_bench.sv */
// Self-checking bench for the proximity sensing register block
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected %0t got %h want %h", $time, a, e); end end
module pxs_sense_ctrl_bench;
   import pxs_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic scl, sda_pull, sda_oe, int_oe, fe_start, bias_on, sun_cancel_en, ok;
   logic fe_valid = 1'b0;
   logic fe_sun = 1'b0;
   logic [11:0] fe_result = 12'h000;
   logic [2:0] fe_dly = 3'h0;
   logic [7:0] integ_ctrl;
   logic [3:0] emitter_current;
   logic [15:0] rdat;
   int checks = 0;
   int bad_count = 0;
   // Open-drain data wire with pull-up
   wire sda = !(sda_pull || sda_oe);
   always #25 clk_sys = !clk_sys;
   // Front end answers each request four cycles later
   always @(posedge clk_sys) begin
      fe_dly <= #5 {fe_dly[1:0], fe_start};
      fe_valid <= #5 fe_dly[2];
   end
   pxs_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
   pxs_sense_ctrl #(.TICK_CYCLES(20), .IDENT_LO(8'h3C), .IDENT_HI(8'h00)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe(sda_oe), .int_o(), .int_oe(int_oe), .fe_start(fe_start),
      .fe_result(fe_result), .fe_valid(fe_valid), .fe_sun(fe_sun), .bias_on(bias_on),
      .integ_ctrl(integ_ctrl), .emitter_current(emitter_current),
      .sun_cancel_en(sun_cancel_en));
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.wr(DEV_ADDR, c, d, ok);
      `CHK(ok, 1'b1)
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
      host.rd(c, rdat);
      `CHK(rdat, e)
   endtask
   // Let the scheduler run, then resume just after a rising edge
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #5;
   endtask
   task automatic final_report;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence; every wait is a fixed, finite bus slot or clock count
   initial begin
      repeat (3) @(posedge clk_sys);
      #5 resetn = 1'b1;
      repeat (3) @(posedge clk_sys);
      #5;
      rdchk(CMD_CONF1, 16'h0001);
      rdchk(CMD_CONF2, 16'h0001);
      rdchk(CMD_IDENT, 16'h003C);
      wr(CMD_CONF1, 16'h0003);
      wr(CMD_CONF1, 16'h0083);
      `CHK(bias_on, 1'b1)
      wr(CMD_CONF3, 16'hEF48);
      `CHK(emitter_current, 4'hF)
      `CHK(sun_cancel_en, 1'b1)
      wr(CMD_CONF3, 16'hCF48);
      `CHK(sun_cancel_en, 1'b0)
      wr(CMD_CONF2, 16'hBC0C);
      `CHK(integ_ctrl, 8'hBC)
      wr(CMD_THL, 16'hF100);
      rdchk(CMD_THL, 16'h0100);
      wr(CMD_THH, 16'h0200);
      wr(CMD_CANC, 16'hFFFF);
      rdchk(CMD_CANC, 16'h0FFF);
      wr(CMD_RES, 16'h1234);
      rdchk(CMD_RES, 16'h0000);
      fe_result = 12'h345;
      wr(CMD_CONF3, 16'hCF68);
      rdchk(CMD_CONF3, 16'hCF48);
      rdchk(CMD_RES, 16'h0345);
      `CHK(int_oe, 1'b1)
      rdchk(CMD_FLAG, 16'h0200);
      `CHK(int_oe, 1'b0)
      // Calibration of two long samples with sunlight seen on the way
      fe_sun = 1'b1;
      wr(CMD_ACAL, 16'h00DD);
      rdchk(CMD_ACRES, 16'hC000);
      idle(700);
      fe_sun = 1'b0;
      rdchk(CMD_ACRES, 16'h4345);
      rdchk(CMD_ACAL, 16'h00D9);
      `CHK(int_oe, 1'b1)
      rdchk(CMD_FLAG, 16'h3000);
      `CHK(int_oe, 1'b0)
      host.wr(7'h61, CMD_CONF1, 16'h0001, ok);
      `CHK(ok, 1'b0)
      rdchk(CMD_CONF1, 16'h0083);
      // Automatic periodic mode: a drop below the low threshold
      fe_result = 12'h050;
      wr(CMD_CONF3, 16'hCF08);
      idle(250);
      rdchk(CMD_RES, 16'h0050);
      rdchk(CMD_FLAG, 16'h0100);
      // First-high mode: a drop alone is ignored until a rise was seen
      fe_result = 12'h150;
      wr(CMD_CONF2, 16'hBC08);
      idle(250);
      fe_result = 12'h050;
      idle(250);
      rdchk(CMD_FLAG, 16'h0000);
      fe_result = 12'h345;
      idle(250);
      fe_result = 12'h050;
      idle(250);
      rdchk(CMD_FLAG, 16'h0300);
      // Logic output mode: the pin follows the near and far state
      fe_result = 12'h345;
      wr(CMD_CONF2, 16'hBC04);
      idle(250);
      `CHK(int_oe, 1'b1)
      fe_result = 12'h050;
      idle(250);
      `CHK(int_oe, 1'b0)
      final_report();
   end
endmodule
